// >>> src/ddrmr_core.sv
// DDR2 device side mode register decode, DLL control and status port
//
// Chosen here: the register addresses and the plain strobed port.
module ddrmr_core
  import ddrmr_pkg::*;
#(
  parameter int LOCK_CLKS = DLL_LOCK_CLKS
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire ddrmr_pins_t pins_in,
  input wire logic [7:0] bus_addr_in,
  input wire logic [31:0] bus_wdata_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  output logic [31:0] bus_rdata_out,
  output ddrmr_mr_t mr_out,
  output ddrmr_emr1_t emr1_out,
  output logic clk_active_out,
  output logic dll_on_out,
  output logic dll_locked_out,
  output logic dm_enable_out,
  output logic ready_out
);
  // ==========================================================
  // Pin synchroniser
  ddrmr_pins_t pins_s1_reg, pins_s2_reg;
  logic cke_prev_reg;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
      cke_prev_reg <= 1'b0;
    end else begin
      pins_s1_reg <= pins_in;
      pins_s2_reg <= pins_s1_reg;
      cke_prev_reg <= pins_s2_reg.cke;
    end
  end

  // ==========================================================
  // Command decode
  logic [3:0] cmd;
  logic cmd_clocked, mode_wr, sr_entry, sr_exit;
  logic ctrl_dec_en_reg, sr_active_reg;

  assign cmd = {pins_s2_reg.cs_n, pins_s2_reg.ras_n,
                pins_s2_reg.cas_n, pins_s2_reg.we_n};
  assign cmd_clocked = cke_prev_reg && pins_s2_reg.cke;
  assign mode_wr = cmd_clocked && (cmd == CMD_MRS) && ctrl_dec_en_reg;
  assign sr_entry = cke_prev_reg && !pins_s2_reg.cke && (cmd == CMD_REF)
                    && !sr_active_reg;
  assign sr_exit = sr_active_reg && pins_s2_reg.cke;

  // ==========================================================
  // Mode registers; whole register replaced, array never addressed
  logic [13:0] mr_reg, emr1_reg, emr2_reg, emr3_reg;
  logic mr_done_reg, emr1_done_reg;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      mr_reg <= MODE_RST;
      emr1_reg <= MODE_RST;
      emr2_reg <= MODE_RST;
      emr3_reg <= MODE_RST;
    end else if (mode_wr) begin
      if (pins_s2_reg.ba == BA_MR) begin
        mr_reg <= pins_s2_reg.addr;
      end else if (pins_s2_reg.ba == BA_EMR1) begin
        emr1_reg <= pins_s2_reg.addr;
      end else if (pins_s2_reg.ba == BA_EMR2) begin
        emr2_reg <= pins_s2_reg.addr;
      end else if (pins_s2_reg.ba == BA_EMR3) begin
        emr3_reg <= pins_s2_reg.addr;
      end
    end
  end

  // MR and EMR1 count as undefined until an MRS command writes each one
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      mr_done_reg <= 1'b0;
      emr1_done_reg <= 1'b0;
    end else if (mode_wr) begin
      if (pins_s2_reg.ba == BA_MR) begin
        mr_done_reg <= 1'b1;
      end
      if (pins_s2_reg.ba == BA_EMR1) begin
        emr1_done_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Clocking, self refresh and DLL control
  logic clk_active_reg, dll_on_reg, dll_restart;
  logic lock_done;
  ddrmr_mr_t mr_view;
  ddrmr_emr1_t emr1_view;

  assign mr_view = ddrmr_mr_t'(mr_reg);
  assign emr1_view = ddrmr_emr1_t'(emr1_reg);

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      clk_active_reg <= 1'b0;
    end else begin
      clk_active_reg <= pins_s2_reg.cke;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sr_active_reg <= 1'b0;
    end else if (sr_entry) begin
      sr_active_reg <= 1'b1;
    end else if (sr_exit) begin
      sr_active_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      dll_on_reg <= 1'b0;
    end else if (sr_entry) begin
      dll_on_reg <= 1'b0;
    end else if (sr_exit) begin
      dll_on_reg <= !emr1_view.dll_dis;
    end else if (mode_wr && pins_s2_reg.ba == BA_EMR1) begin
      dll_on_reg <= !pins_s2_reg.addr[0];
    end
  end

  // Restart lock wait on DLL-reset MRS, self refresh exit or DLL off
  assign dll_restart = (mode_wr && pins_s2_reg.ba == BA_MR
                        && pins_s2_reg.addr[8]) || sr_exit || !dll_on_reg;

  ddrmr_lock_timer #(
    .CYCLES(LOCK_CLKS)
  ) u_lock (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .restart_in(dll_restart),
    .run_in(clk_active_reg),
    .done_out(lock_done)
  );

  // ==========================================================
  // Registered status outputs
  logic dll_locked_reg, dm_enable_reg, ready_reg;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      dll_locked_reg <= 1'b0;
      dm_enable_reg <= 1'b1;
      ready_reg <= 1'b0;
    end else begin
      // Drop lock in the same cycle as any restart of the wait
      dll_locked_reg <= lock_done && dll_on_reg && !dll_restart;
      dm_enable_reg <= !emr1_view.rdqs_en;
      ready_reg <= mr_done_reg && emr1_done_reg;
    end
  end

  // ==========================================================
  // Register port
  logic [31:0] rdata_reg;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      ctrl_dec_en_reg <= CTRL_DEC_EN_RST;
    end else if (bus_wr_in && bus_addr_in == CTRL_OFF) begin
      ctrl_dec_en_reg <= bus_wdata_in[CTRL_DEC_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      rdata_reg <= '0;
    end else if (bus_rd_in) begin
      if (bus_addr_in == STATUS_OFF) begin
        rdata_reg <= {25'h000_0000, sr_active_reg, ready_reg,
                      emr1_done_reg, mr_done_reg, dll_locked_reg,
                      dll_on_reg, clk_active_reg};
      end else if (bus_addr_in == MR_OFF) begin
        rdata_reg <= {18'h0_0000, mr_reg};
      end else if (bus_addr_in == EMR1_OFF) begin
        rdata_reg <= {18'h0_0000, emr1_reg};
      end else if (bus_addr_in == EMR2_OFF) begin
        rdata_reg <= {18'h0_0000, emr2_reg};
      end else if (bus_addr_in == EMR3_OFF) begin
        rdata_reg <= {18'h0_0000, emr3_reg};
      end else if (bus_addr_in == CTRL_OFF) begin
        rdata_reg <= {31'h0000_0000, ctrl_dec_en_reg};
      end else begin
        rdata_reg <= '0;
      end
    end else begin
      rdata_reg <= '0;
    end
  end

  assign bus_rdata_out = rdata_reg;
  assign mr_out = mr_view;
  assign emr1_out = emr1_view;
  assign clk_active_out = clk_active_reg;
  assign dll_on_out = dll_on_reg;
  assign dll_locked_out = dll_locked_reg;
  assign dm_enable_out = dm_enable_reg;
  assign ready_out = ready_reg;

  // ==========================================================
  // Assertions
  mr_load_a: assert property (@(posedge ref_clk_in) disable iff (srst_in)
    mode_wr && pins_s2_reg.ba == BA_MR |=> mr_reg == $past(pins_s2_reg.addr))
    else $error("MR not loaded from command");
  emr1_load_a: assert property (@(posedge ref_clk_in)
    disable iff (srst_in)
    mode_wr && pins_s2_reg.ba == BA_EMR1
    |=> emr1_reg == $past(pins_s2_reg.addr))
    else $error("EMR1 not loaded from command");
  mode_hold_a: assert property (@(posedge ref_clk_in)
    disable iff (srst_in)
    !mode_wr |=> $stable(mr_reg) && $stable(emr1_reg))
    else $error("Mode register changed without write");
  sr_dll_off_a: assert property (@(posedge ref_clk_in)
    disable iff (srst_in)
    sr_entry |=> !dll_on_reg ##1 !dll_locked_reg)
    else $error("DLL still on in self refresh");
  sr_exit_lock_a: assert property (@(posedge ref_clk_in)
    disable iff (srst_in)
    sr_exit |=> !lock_done [*2])
    else $error("Lock wait not restarted on exit");
  clk_follow_a: assert property (@(posedge ref_clk_in)
    disable iff (srst_in)
    ##1 clk_active_reg == $past(pins_s2_reg.cke))
    else $error("Clocking does not follow CKE");
  dm_rdqs_a: assert property (@(posedge ref_clk_in)
    disable iff (srst_in)
    emr1_view.rdqs_en |=> !dm_enable_reg)
    else $error("Data mask active with redundant strobe");
  ready_gate_a: assert property (@(posedge ref_clk_in)
    disable iff (srst_in)
    ready_reg |-> $past(mr_done_reg) && $past(emr1_done_reg))
    else $error("Ready before MR and EMR1 written");
  dll_reset_a: assert property (@(posedge ref_clk_in)
    disable iff (srst_in)
    mode_wr && pins_s2_reg.ba == BA_MR && pins_s2_reg.addr[8]
    |=> !dll_locked_reg ##1 !dll_locked_reg)
    else $error("DLL reset did not drop lock");
endmodule // ddrmr_core

// >>> src/ddrmr_lock_timer.sv
// Restartable clock counter flagging the end of the DLL lock wait
module ddrmr_lock_timer #(
  parameter int CYCLES = 200
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic restart_in,
  input wire logic run_in,
  output logic done_out
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] count_reg;
  logic done_reg;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in || restart_in) begin
      count_reg <= '0;
      done_reg <= 1'b0;
    end else if (run_in && !done_reg) begin
      count_reg <= count_reg + CW'(1);
      done_reg <= (count_reg == LAST);
    end
  end

  assign done_out = done_reg;
endmodule // ddrmr_lock_timer

// >>> src/ddrmr_pkg.sv
// Package of constants and carrier types for the mode register block
package ddrmr_pkg;
  // ==========================================================
  // Register bus offsets
  localparam logic [7:0] STATUS_OFF = 8'h00;
  localparam logic [7:0] MR_OFF = 8'h04;
  localparam logic [7:0] EMR1_OFF = 8'h08;
  localparam logic [7:0] EMR2_OFF = 8'h0C;
  localparam logic [7:0] EMR3_OFF = 8'h10;
  localparam logic [7:0] CTRL_OFF = 8'h14;
  // ==========================================================
  // Reset values and field positions
  localparam logic [13:0] MODE_RST = 14'h0000;
  localparam logic CTRL_DEC_EN_RST = 1'b1;
  localparam int CTRL_DEC_EN_BIT = 0;
  // ==========================================================
  // Bank selects and command pin codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [2:0] BA_MR = 3'h0;
  localparam logic [2:0] BA_EMR1 = 3'h1;
  localparam logic [2:0] BA_EMR2 = 3'h2;
  localparam logic [2:0] BA_EMR3 = 3'h3;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  // ==========================================================
  // Timing: DLL lock wait counted in clocks; burst length codes
  localparam int DLL_LOCK_CLKS = 200;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [13:0] addr;
  } ddrmr_pins_t;

  typedef struct packed {
    logic [1:0] rsv;
    logic [2:0] wr_rec;
    logic dll_reset;
    logic test_mode;
    logic [2:0] cas_lat;
    logic burst_seq;
    logic [2:0] burst_len;
  } ddrmr_mr_t;

  typedef struct packed {
    logic [1:0] rsv;
    logic rdqs_en;
    logic dqs_n_dis;
    logic [2:0] ocd_mode;
    logic rtt_hi;
    logic [2:0] add_lat;
    logic rtt_lo;
    logic reduced_drive;
    logic dll_dis;
  } ddrmr_emr1_t;
endpackage

// >>> tb/ddr2_init_mode_register_setup_bench.sv
// Self-checking bench for the mode register block
module ddr2_init_mode_register_setup_bench
  import ddrmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LOCK = 8;
  localparam logic [13:0] MR_V = 14'h0A53;
  localparam logic [13:0] EMR1_V = 14'h0046;
  logic ref_clk_in, srst_in, bus_wr_in, bus_rd_in;
  logic [7:0] bus_addr_in;
  logic [31:0] bus_wdata_in, bus_rdata_out, d;
  ddrmr_pins_t pins;
  ddrmr_mr_t mr_out;
  ddrmr_emr1_t emr1_out;
  logic clk_active_out, dll_on_out, dll_locked_out, dm_enable_out, ready_out;
  int failures, tests_run, cycles;

  ddrmr_core #(.LOCK_CLKS(LOCK)) i_dut (.ref_clk_in(ref_clk_in),
    .srst_in(srst_in), .pins_in(pins), .bus_addr_in(bus_addr_in),
    .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in),
    .bus_rd_in(bus_rd_in), .bus_rdata_out(bus_rdata_out), .mr_out(mr_out),
    .emr1_out(emr1_out), .clk_active_out(clk_active_out),
    .dll_on_out(dll_on_out), .dll_locked_out(dll_locked_out),
    .dm_enable_out(dm_enable_out), .ready_out(ready_out));
  ddrmr_ctrl_model i_ctrl (.ref_clk_in(ref_clk_in), .pins_out(pins));

  always #2.5 ref_clk_in = ~ref_clk_in;

  // ==========================================================
  // Checks, bus tasks and closing report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_in);
    bus_wr_in <= 1'b1;
    bus_addr_in <= a;
    bus_wdata_in <= v;
    @(posedge ref_clk_in);
    bus_wr_in <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk_in);
    bus_rd_in <= 1'b1;
    bus_addr_in <= a;
    @(posedge ref_clk_in);
    bus_rd_in <= 1'b0;
    #1 v = bus_rdata_out;
    @(posedge ref_clk_in);
    #1 chk(bus_rdata_out, 32'h0000_0000);
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 50000) begin
      failures++;
      test_done();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    ref_clk_in = 1'b0;
    srst_in = 1'b1;
    {bus_wr_in, bus_rd_in, bus_addr_in, bus_wdata_in} = '0;
    {failures, tests_run, cycles} = '0;
    repeat (2) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    bus_rd(STATUS_OFF, d); chk(d, 32'h0000_0000);
    bus_rd(CTRL_OFF, d); chk(d, 32'h0000_0001);
    chk(dm_enable_out, 1'b1);
    i_ctrl.issue(CMD_MRS, BA_MR, 14'h1234);
    chk(mr_out, 14'h0000);
    chk(clk_active_out, 1'b0);
    i_ctrl.power_up();
    chk(clk_active_out, 1'b1);
    i_ctrl.init(MR_V, EMR1_V);
    chk(ready_out, 1'b1);
    chk(mr_out, MR_V);
    chk(emr1_out, EMR1_V);
    chk(mr_out.wr_rec, 3'h5);
    chk(mr_out.cas_lat, 3'h5);
    chk(mr_out.burst_len, BL_8);
    chk({dll_on_out, dll_locked_out}, 2'h3);
    bus_rd(STATUS_OFF, d);
    chk(d, 32'h0000_003F);
    bus_rd(MR_OFF, d); chk(d, {18'h0, MR_V});
    bus_rd(EMR1_OFF, d); chk(d, {18'h0, EMR1_V});
    i_ctrl.issue(CMD_MRS, BA_EMR2, 14'h0080);
    i_ctrl.issue(CMD_MRS, BA_EMR3, 14'h1555);
    bus_rd(EMR2_OFF, d); chk(d, 32'h0000_0080);
    bus_rd(EMR3_OFF, d); chk(d, 32'h0000_1555);
    i_ctrl.issue(CMD_MRS, 3'h4, 14'h3FFF);
    i_ctrl.issue(CMD_REF, BA_MR, 14'h3FFF);
    chk(mr_out, MR_V);
    chk(emr1_out, EMR1_V);
    i_ctrl.issue(CMD_MRS, BA_MR, 14'h0132);
    chk(mr_out, 14'h0132);
    chk(dll_locked_out, 1'b0);
    repeat (20) @(posedge ref_clk_in);
    chk(dll_locked_out, 1'b1);
    bus_wr(CTRL_OFF, 32'h0000_0000);
    i_ctrl.issue(CMD_MRS, BA_MR, 14'h3FFF);
    chk(mr_out, 14'h0132);
    bus_wr(CTRL_OFF, 32'h0000_0001);
    bus_wr(MR_OFF, 32'h0000_3FFF);
    bus_rd(MR_OFF, d); chk(d, 32'h0000_0132);
    bus_rd(8'h3C, d); chk(d, 32'h0000_0000);
    i_ctrl.issue(CMD_MRS, BA_EMR1, EMR1_V | 14'h0801);
    chk({dm_enable_out, dll_on_out, dll_locked_out}, 3'h0);
    i_ctrl.issue(CMD_MRS, BA_EMR1, EMR1_V);
    chk({dm_enable_out, dll_on_out}, 2'h3);
    repeat (20) @(posedge ref_clk_in);
    i_ctrl.sr_enter();
    chk({clk_active_out, dll_on_out}, 2'h0);
    bus_rd(STATUS_OFF, d);
    chk(d, 32'h0000_0078);
    i_ctrl.cke_up();
    chk({clk_active_out, dll_on_out, dll_locked_out}, 3'h6);
    repeat (20) @(posedge ref_clk_in);
    chk(dll_locked_out, 1'b1);
    chk(emr1_out, EMR1_V);
    test_done();
  end
endmodule // ddr2_init_mode_register_setup_bench

// >>> tb/ddrmr_ctrl_model.sv
// Behavioural memory controller driving the DRAM command pins
module ddrmr_ctrl_model
  import ddrmr_pkg::*;
#(
  // 200 us of stable clock and 400 ns of NOPs at a 5 ns period
  parameter int STAB_CLKS = 40000,
  parameter int NOP_CLKS = 80,
  parameter int GAP_CLKS = 4
) (
  input wire logic ref_clk_in,
  output ddrmr_pins_t pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [13:0] EMR1_KEEP = 14'h1C7E;

  // ==========================================================
  // Power ramp: deselect, clock enable low
  initial begin
    pins_out = '1;
    pins_out.cke = 1'b0;
  end

  // ==========================================================
  // One command, held three samples, then deselect and a gap
  task automatic issue(input logic [3:0] code, input logic [2:0] ba,
                       input logic [13:0] a);
    @(posedge ref_clk_in);
    {pins_out.cs_n, pins_out.ras_n, pins_out.cas_n, pins_out.we_n} <= code;
    pins_out.ba <= ba;
    pins_out.addr <= a;
    repeat (3) @(posedge ref_clk_in);
    pins_out.cs_n <= 1'b1;
    pins_out.ba <= ~ba;
    pins_out.addr <= ~a;
    repeat (GAP_CLKS) @(posedge ref_clk_in);
  endtask

  task automatic cke_up();
    @(posedge ref_clk_in);
    pins_out.cke <= 1'b1;
    repeat (GAP_CLKS) @(posedge ref_clk_in);
  endtask

  task automatic sr_enter();
    @(posedge ref_clk_in);
    {pins_out.cs_n, pins_out.ras_n, pins_out.cas_n, pins_out.we_n} <= CMD_REF;
    pins_out.cke <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    pins_out.cs_n <= 1'b1;
    repeat (GAP_CLKS) @(posedge ref_clk_in);
  endtask

  task automatic power_up();
    repeat (STAB_CLKS) @(posedge ref_clk_in);
    cke_up();
    repeat (NOP_CLKS) @(posedge ref_clk_in);
    issue(CMD_PRE, 3'h0, 14'h0400);
  endtask

  // ==========================================================
  // Initialisation from mode writes to OCD exit
  task automatic init(input logic [13:0] mr, input logic [13:0] emr1);
    issue(CMD_MRS, BA_EMR2, 14'h0000);
    issue(CMD_MRS, BA_EMR3, 14'h0000);
    issue(CMD_MRS, BA_EMR1, emr1 & EMR1_KEEP);
    issue(CMD_MRS, BA_MR, mr | 14'h0100);
    issue(CMD_PRE, 3'h0, 14'h0400);
    issue(CMD_REF, 3'h0, 14'h0000);
    issue(CMD_REF, 3'h0, 14'h0000);
    issue(CMD_MRS, BA_MR, mr & 14'h3EFF);
    repeat (DLL_LOCK_CLKS) @(posedge ref_clk_in);
    issue(CMD_MRS, BA_EMR1, (emr1 & EMR1_KEEP) | 14'h0380);
    issue(CMD_MRS, BA_EMR1, emr1 & EMR1_KEEP);
  endtask
endmodule // ddrmr_ctrl_model
